// ### hw/msr_pkg.sv
// package for the motion status readout bank: offsets, bit positions, resets
// assumes byte-wide register port with 8-bit addresses
`default_nettype none
package msr_pkg;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_FEATURE_FLAGS = 8'h1c;
   localparam logic [7:0] ADDR_CORE_FLAGS = 8'h1d;
   localparam logic [7:0] ADDR_STEP_BYTE0 = 8'h1e;
   localparam logic [7:0] ADDR_STEP_BYTE1 = 8'h1f;
   localparam logic [7:0] ADDR_STEP_BYTE2 = 8'h20;
   localparam logic [7:0] ADDR_STEP_BYTE3 = 8'h21;
   localparam logic [7:0] ADDR_DIE_TEMP = 8'h22;
   localparam logic [7:0] ADDR_QUEUE_LOW = 8'h24;
   localparam logic [7:0] ADDR_QUEUE_HIGH = 8'h25;
   // ----------------------------------------
   // feature event flag bit positions
   // ----------------------------------------
   localparam int FEAT_FAULT_BIT = 7;
   localparam int FEAT_MOTION_BIT = 6;
   localparam int FEAT_WAKE_BIT = 5;
   localparam int FEAT_TILT_BIT = 3;
   localparam int FEAT_ACTIVITY_BIT = 2;
   localparam int FEAT_PEDO_BIT = 1;
   localparam logic [7:0] FEAT_USED_MASK = 8'hee;
   // ----------------------------------------
   // core event flag bit positions
   // ----------------------------------------
   localparam int CORE_ACC_READY_BIT = 7;
   localparam int CORE_AUX_READY_BIT = 5;
   localparam int CORE_QUEUE_THRESH_BIT = 1;
   localparam int CORE_QUEUE_FULL_BIT = 0;
   localparam logic [7:0] CORE_USED_MASK = 8'ha3;
   // ----------------------------------------
   // reset values and widths
   // ----------------------------------------
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam int QUEUE_LEVEL_W = 14;
   // pedometer flag source selection
   localparam logic PEDO_MODE_WATERMARK = 1'b0;
   localparam logic PEDO_MODE_STEP = 1'b1;
endpackage
`default_nettype wire

// ### hw/msr_flag_reg.sv
// one clear-on-read event flag byte
// assumes event inputs are one-cycle or level pulses synchronous to i_ref_clk
`default_nettype none
module msr_flag_reg (
   input wire logic i_ref_clk,      // system clock
   input wire logic i_rst,          // sync reset, active high
   input wire logic [7:0] i_set,    // per-bit set requests
   input wire logic [7:0] i_mask,   // implemented bits
   input wire logic i_clear,        // read of this register
   output logic [7:0] o_flags       // flag byte
);
   // set wins over clear so an event during the read is kept
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_flags <= msr_pkg::FLAGS_RESET;
      end else if (i_clear) begin
         o_flags <= i_set & i_mask;
      end else begin
         o_flags <= (o_flags | i_set) & i_mask;
      end
   end
endmodule
`default_nettype wire

// ### hw/msr_status_bank.sv
// motion status readout bank: flag registers, step count, temperature, queue level
// assumes a byte register port: one-cycle read strobe with address, data one cycle later
`default_nettype none
// Overview of operation
// - feature flags clear on read, reset zero
// - feature bits 7,6,5,3,2,1; 4,0 reserved
// - pedometer flag from watermark or step, selectable
// - activity change sets bit 2
// - core flags clear on read, reset zero
// - core bits 7,5,1,0; others reserved
// - step count bytes 0x1e..0x21, little endian
// - temperature signed byte, zero is 23 C
// - queue level low byte at 0x24
// - queue level bits 13..8 at 0x25
module msr_status_bank (
   input wire logic i_ref_clk,              // system clock, 100 MHz
   input wire logic i_rst,                  // sync reset, active high
   input wire logic i_rd,                   // read strobe, one cycle
   input wire logic [7:0] i_addr,           // register address
   output logic [7:0] o_rdata,              // read data, registered
   output logic o_rvalid,                   // read data valid pulse
   input wire logic i_pedo_mode,            // 0 watermark, 1 single step
   input wire logic i_step_watermark,       // step count hit watermark
   input wire logic i_step_detect,          // single step detected
   input wire logic i_activity_change,      // activity class changed
   input wire logic i_tilt_event,           // tilt gesture
   input wire logic i_wake_event,           // wake event
   input wire logic i_motion_event,         // any/no motion change
   input wire logic i_fault_event,          // fault event
   input wire logic i_acc_ready,            // accel sample ready
   input wire logic i_aux_ready,            // aux sample ready
   input wire logic i_queue_thresh,         // queue threshold reached
   input wire logic i_queue_full,           // queue full
   input wire logic [31:0] i_step_count,    // running step count
   input wire logic [7:0] i_temperature,    // signed die temperature
   input wire logic [13:0] i_queue_level    // queue fill level in bytes
);
   // ----------------------------------------
   // flag sources
   // ----------------------------------------
   logic [7:0] feat_set;
   logic [7:0] core_set;
   logic [7:0] feat_flags;
   logic [7:0] core_flags;
   logic pedo_event;
   logic rd_feat;
   logic rd_core;

   always_comb begin
      pedo_event = (i_pedo_mode == msr_pkg::PEDO_MODE_STEP) ? i_step_detect : i_step_watermark;
      feat_set = 8'h00;
      feat_set[msr_pkg::FEAT_FAULT_BIT] = i_fault_event;
      feat_set[msr_pkg::FEAT_MOTION_BIT] = i_motion_event;
      feat_set[msr_pkg::FEAT_WAKE_BIT] = i_wake_event;
      feat_set[msr_pkg::FEAT_TILT_BIT] = i_tilt_event;
      feat_set[msr_pkg::FEAT_ACTIVITY_BIT] = i_activity_change;
      feat_set[msr_pkg::FEAT_PEDO_BIT] = pedo_event;
      core_set = 8'h00;
      core_set[msr_pkg::CORE_ACC_READY_BIT] = i_acc_ready;
      core_set[msr_pkg::CORE_AUX_READY_BIT] = i_aux_ready;
      core_set[msr_pkg::CORE_QUEUE_THRESH_BIT] = i_queue_thresh;
      core_set[msr_pkg::CORE_QUEUE_FULL_BIT] = i_queue_full;
   end

   // flag bytes are the only addresses with a read side effect
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
      return addr == target;
   endfunction

   assign rd_feat = i_rd && addr_hit(i_addr, msr_pkg::ADDR_FEATURE_FLAGS);
   assign rd_core = i_rd && addr_hit(i_addr, msr_pkg::ADDR_CORE_FLAGS);

   // ----------------------------------------
   // flag registers
   // ----------------------------------------
   msr_flag_reg u_feat (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_set(feat_set),
      .i_mask(msr_pkg::FEAT_USED_MASK),
      .i_clear(rd_feat),
      .o_flags(feat_flags)
   );

   msr_flag_reg u_core (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_set(core_set),
      .i_mask(msr_pkg::CORE_USED_MASK),
      .i_clear(rd_core),
      .o_flags(core_flags)
   );

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   logic [7:0] next_rdata;

   always_comb begin
      if (i_addr == msr_pkg::ADDR_FEATURE_FLAGS) begin
         next_rdata = feat_flags;
      end else if (i_addr == msr_pkg::ADDR_CORE_FLAGS) begin
         next_rdata = core_flags;
      end else if (i_addr == msr_pkg::ADDR_STEP_BYTE0) begin
         next_rdata = i_step_count[7:0];
      end else if (i_addr == msr_pkg::ADDR_STEP_BYTE1) begin
         next_rdata = i_step_count[15:8];
      end else if (i_addr == msr_pkg::ADDR_STEP_BYTE2) begin
         next_rdata = i_step_count[23:16];
      end else if (i_addr == msr_pkg::ADDR_STEP_BYTE3) begin
         next_rdata = i_step_count[31:24];
      end else if (i_addr == msr_pkg::ADDR_DIE_TEMP) begin
         // passed through raw; offset to 23 C is software's job
         next_rdata = i_temperature;
      end else if (i_addr == msr_pkg::ADDR_QUEUE_LOW) begin
         next_rdata = i_queue_level[7:0];
      end else if (i_addr == msr_pkg::ADDR_QUEUE_HIGH) begin
         next_rdata = {2'b00, i_queue_level[13:8]};
      end else begin
         next_rdata = msr_pkg::UNMAPPED_READ;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_rdata <= msr_pkg::BYTE_RESET;
      end else if (i_rd) begin
         o_rdata <= next_rdata;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= i_rd;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_feat_read;
      i_rd && i_addr == msr_pkg::ADDR_FEATURE_FLAGS;
   endsequence

   sequence s_core_read;
      i_rd && i_addr == msr_pkg::ADDR_CORE_FLAGS;
   endsequence

   sequence s_feat_quiet_read;
      s_feat_read ##0 (feat_set == 8'h00);
   endsequence

   sequence s_core_quiet_read;
      s_core_read ##0 (core_set == 8'h00);
   endsequence

   a_feat_clear_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_feat_read |=> (feat_flags == (($past(feat_set)) & msr_pkg::FEAT_USED_MASK)))
      else $error("feature flags not cleared by read");

   a_core_clear_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_core_read |=> (core_flags == (($past(core_set)) & msr_pkg::CORE_USED_MASK)))
      else $error("core flags not cleared by read");

   a_feat_reserved_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (feat_flags[4] == 1'b0) && (feat_flags[0] == 1'b0))
      else $error("feature reserved bit set");

   a_core_reserved_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (core_flags & ~msr_pkg::CORE_USED_MASK) == 8'h00)
      else $error("core reserved bit set");

   a_pedo_step_mode: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_pedo_mode && i_step_detect) |=> feat_flags[msr_pkg::FEAT_PEDO_BIT])
      else $error("step detect did not set pedometer flag");

   a_pedo_mark_mode: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (!i_pedo_mode && i_step_watermark) |=> feat_flags[msr_pkg::FEAT_PEDO_BIT])
      else $error("watermark did not set pedometer flag");

   a_activity_sets: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_activity_change |=> feat_flags[msr_pkg::FEAT_ACTIVITY_BIT])
      else $error("activity change flag not set");

   a_event_kept: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_feat_read ##0 i_wake_event) |=> feat_flags[msr_pkg::FEAT_WAKE_BIT])
      else $error("event lost during clearing read");

   a_core_event_kept: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_core_read ##0 i_acc_ready) |=> core_flags[msr_pkg::CORE_ACC_READY_BIT])
      else $error("core event lost during clearing read");

   a_step_msb_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_rd && i_addr == msr_pkg::ADDR_STEP_BYTE3) |=> o_rvalid && o_rdata == $past(i_step_count[31:24]))
      else $error("step count top byte wrong");

   a_step_lsb_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_rd && i_addr == msr_pkg::ADDR_STEP_BYTE0) |=> o_rdata == $past(i_step_count[7:0]))
      else $error("step count low byte wrong");

   a_temp_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_rd && i_addr == msr_pkg::ADDR_DIE_TEMP) |=> o_rdata == $past(i_temperature))
      else $error("temperature read wrong");

   a_queue_low_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_rd && i_addr == msr_pkg::ADDR_QUEUE_LOW) |=> o_rdata == $past(i_queue_level[7:0]))
      else $error("queue low byte wrong");

   a_queue_high_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_rd && i_addr == msr_pkg::ADDR_QUEUE_HIGH) |=> o_rdata == {2'b00, $past(i_queue_level[13:8])})
      else $error("queue high byte wrong");

   // ----------------------------------------
   // read port and per-bit checks
   // ----------------------------------------
   a_feat_read_data: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_feat_read |=> o_rdata == $past(feat_flags))
      else $error("feature flags read wrong");

   a_core_read_data: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_core_read |=> o_rdata == $past(core_flags))
      else $error("core flags read wrong");

   a_feat_sticky: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !rd_feat |=> feat_flags == (($past(feat_flags) | $past(feat_set)) & msr_pkg::FEAT_USED_MASK))
      else $error("feature flags changed without read");

   a_core_sticky: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !rd_core |=> core_flags == (($past(core_flags) | $past(core_set)) & msr_pkg::CORE_USED_MASK))
      else $error("core flags changed without read");

   a_feat_reset_zero: assert property (@(posedge i_ref_clk)
      $past(i_rst) |-> feat_flags == msr_pkg::FLAGS_RESET)
      else $error("feature flags not zero after reset");

   a_core_reset_zero: assert property (@(posedge i_ref_clk)
      $past(i_rst) |-> core_flags == msr_pkg::FLAGS_RESET)
      else $error("core flags not zero after reset");

   a_port_reset_zero: assert property (@(posedge i_ref_clk)
      $past(i_rst) |-> !o_rvalid && o_rdata == msr_pkg::BYTE_RESET)
      else $error("read port not idle after reset");

   a_rvalid_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_rd |=> o_rvalid)
      else $error("read valid missing");

   a_rvalid_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !i_rd |=> !o_rvalid)
      else $error("read valid without read");

   a_rdata_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !i_rd |=> $stable(o_rdata))
      else $error("read data changed without read");

   a_fault_sets: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_fault_event |=> feat_flags[msr_pkg::FEAT_FAULT_BIT])
      else $error("fault flag not set");

   a_motion_sets: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_motion_event |=> feat_flags[msr_pkg::FEAT_MOTION_BIT])
      else $error("motion flag not set");

   a_wake_sets: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_wake_event |=> feat_flags[msr_pkg::FEAT_WAKE_BIT])
      else $error("wake flag not set");

   a_tilt_sets: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_tilt_event |=> feat_flags[msr_pkg::FEAT_TILT_BIT])
      else $error("tilt flag not set");

   a_acc_sets: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_acc_ready |=> core_flags[msr_pkg::CORE_ACC_READY_BIT])
      else $error("accel ready flag not set");

   a_aux_sets: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_aux_ready |=> core_flags[msr_pkg::CORE_AUX_READY_BIT])
      else $error("aux ready flag not set");

   a_thresh_sets: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_queue_thresh |=> core_flags[msr_pkg::CORE_QUEUE_THRESH_BIT])
      else $error("queue threshold flag not set");

   a_full_sets: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_queue_full |=> core_flags[msr_pkg::CORE_QUEUE_FULL_BIT])
      else $error("queue full flag not set");

   a_step_byte1_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_rd && i_addr == msr_pkg::ADDR_STEP_BYTE1) |=> o_rdata == $past(i_step_count[15:8]))
      else $error("step count byte one wrong");

   a_step_byte2_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_rd && i_addr == msr_pkg::ADDR_STEP_BYTE2) |=> o_rdata == $past(i_step_count[23:16]))
      else $error("step count byte two wrong");

   a_unmapped_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_rd && (i_addr < msr_pkg::ADDR_FEATURE_FLAGS || i_addr > msr_pkg::ADDR_QUEUE_HIGH))
      |=> o_rdata == msr_pkg::UNMAPPED_READ)
      else $error("unmapped read not zero");

   a_feat_reread_empty: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_feat_quiet_read ##1 (feat_set == 8'h00) ##1 s_feat_read |=> o_rdata == msr_pkg::FLAGS_RESET)
      else $error("feature flags not empty on second read");

   a_core_reread_empty: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_core_quiet_read ##1 (core_set == 8'h00) ##1 s_core_read |=> o_rdata == msr_pkg::FLAGS_RESET)
      else $error("core flags not empty on second read");
endmodule
`default_nettype wire

// ### tb/msr_host_model.sv
// host side model: issues single register reads on the byte port
// assumes the caller enters read_reg at a falling clock edge
`default_nettype none
module msr_host_model (
   input wire logic i_ref_clk,     // system clock
   output logic o_rd,              // read strobe
   output logic [7:0] o_addr,      // register address
   input wire logic [7:0] i_rdata, // read data
   input wire logic i_rvalid       // read data valid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_rd = 1'b0;
      o_addr = 8'h00;
   end
   // ok is high only for a one-cycle valid pulse
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      o_rd = 1'b1;
      o_addr = addr;
      @(negedge i_ref_clk);
      o_rd = 1'b0;
      // released address shows garbage, not the old value
      o_addr = ~addr;
      data = i_rdata;
      ok = i_rvalid;
      @(negedge i_ref_clk);
      ok = ok & (i_rvalid === 1'b0);
   endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the status readout bank
// assumes the host model drives the read port; events driven at falling edge
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, rd, rvalid, pedo_mode;
   logic [7:0] addr, rdata, temp;
   logic [10:0] ev;
   logic [31:0] steps;
   logic [13:0] qlvl;
   int err_total = 0;
   int n_compared = 0;
   msr_host_model u_host (.i_ref_clk(clk), .o_rd(rd), .o_addr(addr), .i_rdata(rdata), .i_rvalid(rvalid));
   msr_status_bank u_dut (.i_ref_clk(clk), .i_rst(rst), .i_rd(rd), .i_addr(addr), .o_rdata(rdata),
      .o_rvalid(rvalid), .i_pedo_mode(pedo_mode), .i_step_watermark(ev[0]), .i_step_detect(ev[1]),
      .i_activity_change(ev[2]), .i_tilt_event(ev[3]), .i_wake_event(ev[4]), .i_motion_event(ev[5]),
      .i_fault_event(ev[6]), .i_acc_ready(ev[7]), .i_aux_ready(ev[8]), .i_queue_thresh(ev[9]),
      .i_queue_full(ev[10]), .i_step_count(steps), .i_temperature(temp), .i_queue_level(qlvl));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ----------------------------------------
   // checking and access tasks
   // ----------------------------------------
   task automatic results;
      if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      u_host.read_reg(a, d, ok);
      check({ok, d}, {1'b1, exp});
   endtask
   // one-cycle event, read it, read it cleared, other flag byte untouched
   task automatic run_case(input logic m, input logic [10:0] e, input logic [7:0] a, input logic [7:0] exp);
      pedo_mode = m;
      ev = e;
      @(negedge clk);
      ev = '0;
      rd_chk(a, exp);
      rd_chk(a, 8'h00);
      rd_chk(a ^ 8'h01, 8'h00);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      pedo_mode = 1'b0;
      ev = '0;
      steps = '0;
      temp = '0;
      qlvl = '0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      // reset values, unmapped 0x23 and 0x30 included
      for (int a = 8'h1c; a <= 8'h25; a++) rd_chk(8'(a), 8'h00);
      rd_chk(8'h30, 8'h00);
      run_case(1'b0, 11'h040, 8'h1c, 8'h80);
      run_case(1'b0, 11'h020, 8'h1c, 8'h40);
      run_case(1'b0, 11'h010, 8'h1c, 8'h20);
      run_case(1'b0, 11'h008, 8'h1c, 8'h08);
      run_case(1'b0, 11'h004, 8'h1c, 8'h04);
      run_case(1'b0, 11'h001, 8'h1c, 8'h02);
      run_case(1'b0, 11'h002, 8'h1c, 8'h00);
      run_case(1'b1, 11'h002, 8'h1c, 8'h02);
      run_case(1'b1, 11'h001, 8'h1c, 8'h00);
      run_case(1'b0, 11'h080, 8'h1d, 8'h80);
      run_case(1'b0, 11'h100, 8'h1d, 8'h20);
      run_case(1'b0, 11'h200, 8'h1d, 8'h02);
      run_case(1'b0, 11'h400, 8'h1d, 8'h01);
      // all events at once: reserved bits stay low
      ev = 11'h7ff;
      @(negedge clk);
      ev = '0;
      rd_chk(8'h1c, 8'hee);
      // core flags still pending; a reset must drop them
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      rd_chk(8'h1d, 8'h00);
      ev = 11'h7ff;
      @(negedge clk);
      ev = '0;
      rd_chk(8'h1d, 8'ha3);
      rd_chk(8'h1c, 8'hee);
      // event arriving during the clearing read survives; event lasts only the read edge
      ev = 11'h010;
      fork
         rd_chk(8'h1c, 8'h00);
         begin
            @(negedge clk);
            ev = '0;
         end
      join
      rd_chk(8'h1c, 8'h20);
      ev = 11'h080;
      fork
         rd_chk(8'h1d, 8'h00);
         begin
            @(negedge clk);
            ev = '0;
         end
      join
      rd_chk(8'h1d, 8'h80);
      rd_chk(8'h1c, 8'h00);
      // live values, two patterns each
      for (int p = 0; p < 2; p++) begin
         steps = p ? 32'h8000_00ff : 32'ha1b2_c3d4;
         temp = p ? 8'h7f : 8'hf6;
         qlvl = p ? 14'h3fff : 14'h2a5c;
         for (int k = 0; k < 4; k++) rd_chk(8'(8'h1e + k), steps[8 * k +: 8]);
         rd_chk(8'h22, temp);
         // unmapped hole after a nonzero read: data must really change
         rd_chk(8'h23, 8'h00);
         rd_chk(8'h24, qlvl[7:0]);
         rd_chk(8'h25, {2'b00, qlvl[13:8]});
      end
      results();
   end
   // hang guard: far beyond the length of the sequence above
   initial begin
      #200000;
      err_total++;
      results();
   end
endmodule
`default_nettype wire
